// ---- rtl/rx_admit_consts.vh ----
// constants for the receive admission block: register map, fields, resets
`ifndef RX_ADMIT_CONSTS_VH
`define RX_ADMIT_CONSTS_VH
// register offsets (byte addresses, one word each)
`define RA_MAC_CONTROL 8'h00
`define RA_FLOW 8'h04
`define RA_AUTO_FLOW 8'h08
`define RA_ADDR_HI 8'h0c
`define RA_ADDR_LO 8'h10
`define RA_HASH_HI 8'h14
`define RA_HASH_LO 8'h18
`define RA_VLAN_TAG1 8'h1c
`define RA_VLAN_TAG2 8'h20
`define RA_STATUS 8'h24
// mac_control_reg fields
`define MC_MCPASS 0
`define MC_PROMISC 1
`define MC_INVERSE 2
`define MC_HASHONLY 3
`define MC_HASHPERF 4
`define MC_HALFDUP 5
// flow register field
`define FL_ENABLE 0
// auto_flow_config fields
`define AF_LO_LSB 0
`define AF_HI_LSB 8
`define AF_DUR_LSB 16
`define AF_ANY 24
`define AF_ADDR 25
`define AF_MULT 26
`define AF_BRD 27
// reset values
`define AF_RESET 32'h0000_0000
`define TAG1_RESET 16'h8100
`define TAG2_RESET 16'h0000
// frame lengths
`define LEN_MAX 14'd1518
`define LEN_MAX_VLAN 14'd1522
// duration timer time base: 64 ns per tick at 8 ns clock
`define DUR_TICK_NS 64
`define CLK_NS 8
`define DUR_TICK_CYC (`DUR_TICK_NS / `CLK_NS)
// last count of the tick divider: DUR_TICK_CYC - 1 at the divider width
`define DUR_TICK_LAST 4'h7
// fill threshold markers used for software-controlled flow control
`define MARK_ALL_ONES 8'hff
`define MARK_ALL_ZERO 8'h00
`endif

// ---- rtl/rx_admit.v ----
// receive admission: backpressure, vlan recognition, address filtering
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`include "rx_admit_consts.vh"

module rx_admit
(
  // clock and reset
  input wire mclk,
  input wire resetn,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // receive byte stream from the mii side
  input wire rx_frame,
  input wire rx_byte_valid,
  input wire [7:0] rx_byte,
  // receive fifo fill level
  input wire [7:0] rx_fill_level,
  // transmitter state
  input wire tx_busy,
  output wire jam_req,
  // frame verdict
  output reg frame_done,
  output reg frame_accept,
  output reg frame_vlan,
  output reg frame_jammed
);

  // ==========================================================
  // registers
  reg [31:0] ctrl_q;
  reg flow_en_q;
  reg [31:0] afc_q;
  reg [15:0] addr_hi_q;
  reg [31:0] addr_lo_q;
  reg [31:0] hash_hi_q;
  reg [31:0] hash_lo_q;
  reg [15:0] tag1_q;
  reg [15:0] tag2_q;

  wire [47:0] station_addr = {addr_hi_q, addr_lo_q};
  wire [7:0] low_mark = afc_q[`AF_LO_LSB +: 8];
  wire [7:0] high_mark = afc_q[`AF_HI_LSB +: 8];
  wire [7:0] dur_val = afc_q[`AF_DUR_LSB +: 8];

  // ==========================================================
  // crc-32 over one byte, lsb first as the frame crc does
  function [31:0] crc_byte;
    input [31:0] c;
    input [7:0] d;
    integer i;
    reg [31:0] r;
    begin
      r = c;
      for (i = 0; i < 8; i = i + 1)
      begin
        if (r[0] ^ d[i])
          r = (r >> 1) ^ 32'hedb8_8320;
        else
          r = r >> 1;
      end
      crc_byte = r;
    end
  endfunction

  // ==========================================================
  // frame parsing
  reg rx_frame_q;
  reg [13:0] byte_cnt_q;
  reg [47:0] dest_q;
  reg [15:0] type_q;
  reg [31:0] crc_q;
  reg [5:0] hash_idx_q;
  wire frame_start = rx_frame && !rx_frame_q;
  wire frame_end = !rx_frame && rx_frame_q;
  // the byte that comes with the frame start is byte 0 of the new frame
  wire [13:0] cnt_now = frame_start ? 14'h0000 : byte_cnt_q;
  wire [31:0] crc_now = frame_start ? 32'hffff_ffff : crc_q;

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_frame_q <= 1'b0;
      byte_cnt_q <= 14'h0000;
      dest_q <= 48'h0000_0000_0000;
      type_q <= 16'h0000;
      crc_q <= 32'hffff_ffff;
      hash_idx_q <= 6'h00;
    end
    else
    begin
      rx_frame_q <= rx_frame;
      if (frame_start)
      begin
        byte_cnt_q <= 14'h0000;
        crc_q <= 32'hffff_ffff;
      end
      if (rx_frame && rx_byte_valid)
      begin
        if (cnt_now != 14'h3fff)
          byte_cnt_q <= cnt_now + 14'h0001;
        if (cnt_now < 14'd6)
        begin
          dest_q <= {dest_q[39:0], rx_byte};
          crc_q <= crc_byte(crc_now, rx_byte);
        end
        if (cnt_now == 14'd6)
          // reflected crc upper bits of the complemented result
          hash_idx_q <= {~crc_q[26], ~crc_q[27], ~crc_q[28],
                         ~crc_q[29], ~crc_q[30], ~crc_q[31]};
        if (cnt_now == 14'd12 || cnt_now == 14'd13)
          type_q <= {type_q[7:0], rx_byte};
      end
    end
  end

  // ==========================================================
  // vlan, length and address checks
  wire is_vlan = (type_q == tag1_q) || (type_q == tag2_q);
  wire [13:0] max_len = is_vlan ? `LEN_MAX_VLAN : `LEN_MAX;
  wire len_ok = byte_cnt_q <= max_len;
  // first transmitted bit is bit 0 of the first byte
  wire is_mcast = dest_q[40];
  wire is_bcast = &dest_q;
  wire perfect_hit = dest_q == station_addr;
  wire hash_hit = hash_idx_q[5] ? hash_hi_q[hash_idx_q[4:0]]
                                : hash_lo_q[hash_idx_q[4:0]];

  wire m_pass = ctrl_q[`MC_MCPASS];
  wire m_promiscuous_sel = ctrl_q[`MC_PROMISC];
  wire m_inv = ctrl_q[`MC_INVERSE];
  wire m_ho = ctrl_q[`MC_HASHONLY];
  wire m_hp = ctrl_q[`MC_HASHPERF];

  reg addr_ok;
  always @*
  begin
    if (m_promiscuous_sel && !m_inv)
      addr_ok = 1'b1;
    else if (m_inv)
      addr_ok = !perfect_hit;
    else if (m_pass && is_mcast)
      addr_ok = 1'b1;
    else if (m_ho && m_hp)
      addr_ok = hash_hit;
    else if (m_hp && is_mcast)
      addr_ok = hash_hit;
    else
      addr_ok = perfect_hit;
  end

  // ==========================================================
  // backpressure controller
  localparam BP_IDLE = 2'd0;
  localparam BP_ACTIVE = 2'd1;
  localparam BP_PASS_ONE = 2'd2;

  reg [1:0] bp_state_q;
  reg [7:0] dur_cnt_q;
  reg [3:0] tick_cnt_q;
  reg tx_wait_q;
  reg jam_q;
  reg pass_seen_q;

  // all-ones low and all-zero high mean the high mark is always crossed
  wire force_high = (low_mark == `MARK_ALL_ONES) &&
                    (high_mark == `MARK_ALL_ZERO);
  wire above_high = force_high || (rx_fill_level >= high_mark);
  wire below_low = !force_high && (rx_fill_level < low_mark);
  wire bp_on = flow_en_q && ctrl_q[`MC_HALFDUP];
  wire tick = tick_cnt_q == `DUR_TICK_LAST;
  wire dur_done = tick && (dur_cnt_q == dur_val);

  // class select needs the destination, so jam starts after byte 6
  wire class_hit = afc_q[`AF_ANY] ||
                   (afc_q[`AF_ADDR] && perfect_hit) ||
                   (afc_q[`AF_MULT] && is_mcast && !is_bcast) ||
                   (afc_q[`AF_BRD] && is_bcast);
  // a stale count from the last frame must not count at a frame start
  wire da_ready = rx_frame && !frame_start && byte_cnt_q >= 14'd6;

  assign jam_req = jam_q;

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      bp_state_q <= BP_IDLE;
      dur_cnt_q <= 8'h00;
      tick_cnt_q <= 4'h0;
      tx_wait_q <= 1'b0;
      jam_q <= 1'b0;
      pass_seen_q <= 1'b0;
    end
    else if (!bp_on)
    begin
      bp_state_q <= BP_IDLE;
      dur_cnt_q <= 8'h00;
      tick_cnt_q <= 4'h0;
      jam_q <= 1'b0;
      tx_wait_q <= 1'b0;
      pass_seen_q <= 1'b0;
    end
    else
    begin
      if (bp_state_q == BP_ACTIVE)
      begin
        tick_cnt_q <= tick ? 4'h0 : tick_cnt_q + 4'h1;
        if (tick)
          dur_cnt_q <= dur_cnt_q + 8'h01;
      end
      // a frame seen while a transmit is running is not jammed
      if (frame_start)
        tx_wait_q <= tx_busy;
      // jam holds to frame end so other stations defer
      if (frame_end)
        jam_q <= 1'b0;
      else if (bp_state_q == BP_ACTIVE && da_ready && !tx_wait_q &&
               !tx_busy && class_hit && byte_cnt_q == 14'd6 &&
               rx_byte_valid)
        jam_q <= 1'b1;
      case (bp_state_q)
        BP_IDLE:
        begin
          if (above_high)
          begin
            bp_state_q <= BP_ACTIVE;
            dur_cnt_q <= 8'h00;
            tick_cnt_q <= 4'h0;
          end
        end
        BP_ACTIVE:
        begin
          if (below_low)
          begin
            bp_state_q <= BP_IDLE;
            dur_cnt_q <= 8'h00;
            tick_cnt_q <= 4'h0;
          end
          else if (dur_done)
          begin
            bp_state_q <= BP_PASS_ONE;
            // a frame starting right now is the one let through
            pass_seen_q <= frame_start;
          end
        end
        BP_PASS_ONE:
        begin
          if (frame_start)
            pass_seen_q <= 1'b1;
          if (frame_end && pass_seen_q)
          begin
            dur_cnt_q <= 8'h00;
            tick_cnt_q <= 4'h0;
            if (below_low)
              bp_state_q <= BP_IDLE;
            else
              bp_state_q <= BP_ACTIVE;
          end
        end
        default:
          bp_state_q <= BP_IDLE;
      endcase
    end
  end

  // ==========================================================
  // verdict, held from frame end until the next
  reg jammed_q;
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      jammed_q <= 1'b0;
    else if (frame_start)
      jammed_q <= 1'b0;
    else if (jam_q)
      jammed_q <= 1'b1;
  end

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      frame_done <= 1'b0;
      frame_accept <= 1'b0;
      frame_vlan <= 1'b0;
      frame_jammed <= 1'b0;
    end
    else
    begin
      frame_done <= frame_end;
      if (frame_end)
      begin
        // filtered or oversized frames are not received
        frame_accept <= addr_ok && len_ok && !jammed_q;
        frame_vlan <= is_vlan && byte_cnt_q >= 14'd14;
        frame_jammed <= jammed_q;
      end
    end
  end

  // ==========================================================
  // register port
  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_q <= 32'h0000_0000;
      flow_en_q <= 1'b0;
      afc_q <= `AF_RESET;
      addr_hi_q <= 16'hffff;
      addr_lo_q <= 32'hffff_ffff;
      hash_hi_q <= 32'h0000_0000;
      hash_lo_q <= 32'h0000_0000;
      tag1_q <= `TAG1_RESET;
      tag2_q <= `TAG2_RESET;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `RA_MAC_CONTROL: ctrl_q <= {26'h0, reg_wdata[5:0]};
        `RA_FLOW: flow_en_q <= reg_wdata[`FL_ENABLE];
        `RA_AUTO_FLOW: afc_q <= {4'h0, reg_wdata[27:0]};
        `RA_ADDR_HI: addr_hi_q <= reg_wdata[15:0];
        `RA_ADDR_LO: addr_lo_q <= reg_wdata;
        `RA_HASH_HI: hash_hi_q <= reg_wdata;
        `RA_HASH_LO: hash_lo_q <= reg_wdata;
        `RA_VLAN_TAG1: tag1_q <= reg_wdata[15:0];
        `RA_VLAN_TAG2: tag2_q <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `RA_MAC_CONTROL: reg_rdata <= ctrl_q;
        `RA_FLOW: reg_rdata <= {31'h0, flow_en_q};
        `RA_AUTO_FLOW: reg_rdata <= afc_q;
        `RA_ADDR_HI: reg_rdata <= {16'h0, addr_hi_q};
        `RA_ADDR_LO: reg_rdata <= addr_lo_q;
        `RA_HASH_HI: reg_rdata <= hash_hi_q;
        `RA_HASH_LO: reg_rdata <= hash_lo_q;
        `RA_VLAN_TAG1: reg_rdata <= {16'h0, tag1_q};
        `RA_VLAN_TAG2: reg_rdata <= {16'h0, tag2_q};
        `RA_STATUS: reg_rdata <= {24'h0, dur_cnt_q[3:0], 1'b0, jam_q,
                                  bp_state_q};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

endmodule

// ---- verification/rx_admit_assertions.sv ----
// concurrent checks on the receive admission ports
`timescale 1ns/1ns
module rx_admit_assertions
(
  // clock and reset
  input wire mclk,
  input wire resetn,
  // observed ports
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire rx_frame,
  input wire tx_busy,
  input wire jam_req,
  input wire frame_done,
  input wire frame_accept,
  input wire frame_vlan,
  input wire frame_jammed
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // ====================
  // frame close steps
  sequence rx_end;
    $fell(rx_frame);
  endsequence
  sequence jam_verdict;
    frame_done && frame_jammed && !frame_accept;
  endsequence
  chk_done_timing: assert property (rx_end |=> frame_done)
    else $error("verdict not one cycle after frame end");
  chk_done_pulse: assert property (frame_done |=> !frame_done)
    else $error("verdict pulse too long");
  chk_verdict_hold: assert property (!frame_done |->
    $stable({frame_accept, frame_vlan, frame_jammed}))
    else $error("verdict changed without pulse");
  // jam is registered, so it may trail the frame end by one cycle
  chk_jam_framed: assert property (jam_req |-> $past(rx_frame))
    else $error("jam outside a received frame");
  chk_jam_held: assert property (jam_req && rx_frame |=> jam_req)
    else $error("jam dropped inside frame");
  chk_jam_tx_idle: assert property ($rose(jam_req) |->
    !$past(tx_busy)) else $error("jam started while transmitting");
  chk_jam_report: assert property ($fell(rx_frame) && jam_req |=>
    jam_verdict) else $error("jammed frame not reported");
  chk_read_slot: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule
bind rx_admit rx_admit_assertions chk_u (.mclk(mclk), .resetn(resetn),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_frame(rx_frame),
  .tx_busy(tx_busy), .jam_req(jam_req), .frame_done(frame_done),
  .frame_accept(frame_accept), .frame_vlan(frame_vlan),
  .frame_jammed(frame_jammed));

// ---- verification/rx_phy_model.sv ----
// phy side model: feeds received frame bytes to the admission block
`timescale 1ns/1ns
module rx_phy_model
(
  // clock
  input wire mclk,
  // receive byte stream
  output reg rx_frame,
  output reg rx_byte_valid,
  output reg [7:0] rx_byte
);
  reg slow;
  initial
  begin
    rx_frame = 1'b0;
    rx_byte_valid = 1'b0;
    rx_byte = 8'h5a;
    slow = 1'b0;
  end
  // ====================
  // destination, tag at bytes 12-13, index bytes elsewhere; idle data is the last byte inverted
  task send;
    input [47:0] da;
    input [15:0] tag;
    input integer len;
    integer i;
    reg [7:0] b;
    begin
      for (i = 0; i < len; i = i + 1)
      begin
        @(posedge mclk);
        b = i[7:0];
        if (i < 6)
          b = da[47 - 8 * i -: 8];
        if (i == 12)
          b = tag[15:8];
        if (i == 13)
          b = tag[7:0];
        rx_frame <= 1'b1;
        rx_byte_valid <= 1'b1;
        rx_byte <= b;
        if (slow)
        begin
          @(posedge mclk);
          rx_byte_valid <= 1'b0;
          rx_byte <= ~b;
        end
      end
      @(posedge mclk);
      rx_frame <= 1'b0;
      rx_byte_valid <= 1'b0;
      rx_byte <= ~b;
    end
  endtask
endmodule

// ---- verification/rx_admit_test.sv ----
// self-checking bench for the receive admission block
`timescale 1ns/1ns
`include "rx_admit_consts.vh"
module rx_admit_test;
  localparam [47:0] st_addr = 48'h0a0b_0c0d_0e0f;
  localparam [47:0] oth_addr = 48'h0a0b_0c0d_0e0e;
  localparam [47:0] mc_addr = 48'h0100_5e00_0001;
  localparam [47:0] bc_addr = 48'hffff_ffff_ffff;
  reg mclk;
  reg resetn;
  reg [7:0] reg_addr;
  reg [31:0] reg_wdata;
  reg reg_wr;
  reg reg_rd;
  reg [7:0] rx_fill_level;
  reg tx_busy;
  wire [31:0] reg_rdata;
  wire rx_frame;
  wire rx_byte_valid;
  wire [7:0] rx_byte;
  wire jam_req;
  wire frame_done;
  wire frame_accept;
  wire frame_vlan;
  wire frame_jammed;
  integer fails;
  integer cmp_count;
  rx_admit dut_u (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_frame(rx_frame),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte),
    .rx_fill_level(rx_fill_level), .tx_busy(tx_busy), .jam_req(jam_req),
    .frame_done(frame_done), .frame_accept(frame_accept),
    .frame_vlan(frame_vlan), .frame_jammed(frame_jammed));
  rx_phy_model phy_u (.mclk(mclk), .rx_frame(rx_frame),
    .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte));
  initial
  begin
    mclk = 1'b0;
    forever
      #4 mclk = ~mclk;
  end
  // ====================
  // bus, frame and report tasks
  task final_report;
    begin
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk;
    input [31:0] got;
    input [31:0] exp;
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr;
    input [7:0] a;
    input [31:0] d;
    begin
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
    end
  endtask
  task rd;
    input [7:0] a;
    input [31:0] exp;
    begin
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
    end
  endtask
  task pins;
    input [7:0] fill;
    input busy;
    begin
      @(posedge mclk);
      rx_fill_level <= fill;
      tx_busy <= busy;
    end
  endtask
  // exp is {accept, vlan, jammed}
  task fr;
    input [47:0] da;
    input [15:0] tag;
    input integer len;
    input [2:0] exp;
    integer n;
    begin
      phy_u.send(da, tag, len);
      n = 0;
      while (frame_done !== 1'b1 && n < 8)
      begin
        @(posedge mclk);
        #1;
        n = n + 1;
      end
      if (n == 8)
      begin
        fails = fails + 1;
        final_report;
      end
      else
        chk({29'h0, frame_accept, frame_vlan, frame_jammed}, {29'h0, exp});
    end
  endtask
  initial
  begin
    resetn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rx_fill_level = 8'h00;
    tx_busy = 1'b0;
    fails = 0;
    cmp_count = 0;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    rd(`RA_VLAN_TAG1, 32'h0000_8100);
    rd(`RA_ADDR_HI, 32'h0000_ffff);
    rd(`RA_AUTO_FLOW, 32'h0);
    rd(8'h28, 32'h0);
    wr(`RA_ADDR_HI, 32'h0000_0a0b);
    wr(`RA_ADDR_LO, 32'h0c0d_0e0f);
    wr(`RA_VLAN_TAG2, 32'h0000_9100);
    rd(`RA_VLAN_TAG2, 32'h0000_9100);
    wr(`RA_MAC_CONTROL, 32'h00);
    fr(st_addr, 16'h0800, 64, 3'b100);
    fr(oth_addr, 16'h0800, 64, 3'b000);
    fr(mc_addr, 16'h0800, 64, 3'b000);
    wr(`RA_MAC_CONTROL, 32'h04);
    fr(st_addr, 16'h0800, 64, 3'b000);
    fr(oth_addr, 16'h0800, 64, 3'b100);
    wr(`RA_MAC_CONTROL, 32'h02);
    phy_u.slow = 1'b1;
    fr(oth_addr, 16'h0800, 64, 3'b100);
    phy_u.slow = 1'b0;
    fr(bc_addr, 16'h0800, 64, 3'b100);
    wr(`RA_MAC_CONTROL, 32'h01);
    fr(mc_addr, 16'h0800, 64, 3'b100);
    fr(oth_addr, 16'h0800, 64, 3'b000);
    wr(`RA_HASH_HI, 32'hffff_ffff);
    wr(`RA_HASH_LO, 32'hffff_ffff);
    wr(`RA_MAC_CONTROL, 32'h10);
    fr(mc_addr, 16'h0800, 64, 3'b100);
    fr(oth_addr, 16'h0800, 64, 3'b000);
    wr(`RA_MAC_CONTROL, 32'h18);
    fr(oth_addr, 16'h0800, 64, 3'b100);
    wr(`RA_HASH_HI, 32'h0);
    wr(`RA_HASH_LO, 32'h0);
    fr(mc_addr, 16'h0800, 64, 3'b000);
    wr(`RA_MAC_CONTROL, 32'h02);
    fr(oth_addr, 16'h0800, 1518, 3'b100);
    fr(oth_addr, 16'h0800, 1519, 3'b000);
    fr(oth_addr, 16'h8100, 1522, 3'b110);
    fr(oth_addr, 16'h8100, 1523, 3'b010);
    fr(oth_addr, 16'h9100, 1522, 3'b110);
    // backpressure: low 0x10, high 0x20, short duration, any class
    wr(`RA_AUTO_FLOW, 32'h0102_2010);
    wr(`RA_MAC_CONTROL, 32'h22);
    pins(8'h30, 1'b0);
    fr(st_addr, 16'h0800, 64, 3'b100);
    wr(`RA_FLOW, 32'h1);
    rd(`RA_STATUS, 32'h0000_0001);
    fr(st_addr, 16'h0800, 64, 3'b001);
    fr(st_addr, 16'h0800, 64, 3'b100);
    fr(st_addr, 16'h0800, 64, 3'b001);
    pins(8'h00, 1'b0);
    fr(st_addr, 16'h0800, 64, 3'b100);
    pins(8'h18, 1'b0);
    fr(st_addr, 16'h0800, 64, 3'b100);
    // long duration so the timer outlasts the next frames
    wr(`RA_AUTO_FLOW, 32'h0140_00ff);
    pins(8'h00, 1'b0);
    fr(st_addr, 16'h0800, 64, 3'b001);
    pins(8'h00, 1'b1);
    fr(st_addr, 16'h0800, 64, 3'b100);
    pins(8'h00, 1'b0);
    wr(`RA_AUTO_FLOW, 32'h08ff_00ff);
    fr(st_addr, 16'h0800, 64, 3'b100);
    fr(bc_addr, 16'h0800, 64, 3'b001);
    wr(`RA_AUTO_FLOW, 32'h02ff_00ff);
    fr(st_addr, 16'h0800, 64, 3'b001);
    fr(oth_addr, 16'h0800, 64, 3'b100);
    wr(`RA_AUTO_FLOW, 32'h04ff_00ff);
    fr(mc_addr, 16'h0800, 64, 3'b001);
    fr(bc_addr, 16'h0800, 64, 3'b100);
    final_report;
  end
endmodule
